// ### rtl/wwdr_consts.svh
`ifndef WWDR_CONSTS_SVH
`define WWDR_CONSTS_SVH

// register byte offsets
`define WWDR_OFS_KEY 8'h00
`define WWDR_OFS_DIV 8'h04
`define WWDR_OFS_RELOAD 8'h08
`define WWDR_OFS_STATUS 8'h0c
`define WWDR_OFS_WINDOW 8'h10

// key command codes
`define WWDR_KEY_RELOAD 16'haaaa
`define WWDR_KEY_START 16'hcccc

// reset values of the low-power domain copies
`define WWDR_DIV_RST 12'h000
`define WWDR_RELOAD_RST 12'hfff
`define WWDR_WINDOW_RST 12'hfff

// field layout
`define WWDR_VAL_W 12
`define WWDR_DIV_W 3
`define WWDR_KEY_W 16
`define WWDR_PEND_DIV 0
`define WWDR_PEND_RELOAD 1
`define WWDR_PEND_WINDOW 2
`define WWDR_NUM_PEND 3

// slow clock ticks a transfer into the low-power domain takes, at most 5
`define WWDR_LP_TICKS 3
`define WWDR_LP_TICKS_MAX 5

// prescaler: divide by 4 << field, field values above 6 saturate at /256
`define WWDR_DIV_BASE 9'h004
`define WWDR_DIV_SAT 3'h6

`endif

// ### rtl/wwdr_lp_domain.sv
`timescale 1ns/1ps
`default_nettype none
`include "wwdr_consts.svh"
module wwdr_lp_domain #(
  parameter int TICKS = `WWDR_LP_TICKS
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // towards the bus-side logic
  wwdr_lp_if.lp lp
);
  localparam logic [2:0][11:0] RST_VALS = {`WWDR_WINDOW_RST, `WWDR_RELOAD_RST, `WWDR_DIV_RST};
  localparam logic [2:0] LAST_TICK = 3'(TICKS - 1);

  if (TICKS < 1 || TICKS > `WWDR_LP_TICKS_MAX) begin : g_bad_ticks
    $error("wwdr_lp_domain: TICKS must lie in 1..5");
  end

  wwdr_pkg::wwdr_val_t val_reg [3];
  wwdr_pkg::wwdr_val_t hold_reg [3];
  logic [2:0] tick_cnt_reg [3];
  logic [2:0] pend_reg;

  for (genvar i = 0; i < 3; i++) begin : g_field
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        val_reg[i] <= RST_VALS[i];
        hold_reg[i] <= 12'h000;
        tick_cnt_reg[i] <= 3'h0;
        pend_reg[i] <= 1'b0;
      end else if (lp.ce) begin
        // a write while pending is dropped: it may not take effect
        if (lp.wr_req[i] && !pend_reg[i]) begin
          pend_reg[i] <= 1'b1;
          hold_reg[i] <= lp.wr_data;
          tick_cnt_reg[i] <= 3'h0;
        end else if (pend_reg[i] && lp.rc_tick) begin
          if (tick_cnt_reg[i] == LAST_TICK) begin
            val_reg[i] <= hold_reg[i];
            pend_reg[i] <= 1'b0;
          end else begin
            tick_cnt_reg[i] <= tick_cnt_reg[i] + 3'h1;
          end
        end
        // standby wipes the copies; the status flags are not touched by it
        if (lp.standby) begin
          val_reg[i] <= RST_VALS[i];
        end
      end
    end
  end

  assign lp.pend = pend_reg;
  assign lp.div_val = val_reg[`WWDR_PEND_DIV];
  assign lp.reload_val = val_reg[`WWDR_PEND_RELOAD];
  assign lp.window_val = val_reg[`WWDR_PEND_WINDOW];
endmodule : wwdr_lp_domain
`default_nettype wire

// ### rtl/wwdr_lp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wwdr_lp_if;
  logic ce;
  logic rc_tick;
  logic standby;
  logic [2:0] wr_req;
  wwdr_pkg::wwdr_val_t wr_data;
  logic [2:0] pend;
  wwdr_pkg::wwdr_val_t div_val;
  wwdr_pkg::wwdr_val_t reload_val;
  wwdr_pkg::wwdr_val_t window_val;

  modport ctrl (
    output ce, rc_tick, standby, wr_req, wr_data,
    input pend, div_val, reload_val, window_val
  );
  modport lp (
    input ce, rc_tick, standby, wr_req, wr_data,
    output pend, div_val, reload_val, window_val
  );
endinterface : wwdr_lp_if
`default_nettype wire

// ### rtl/wwdr_pkg.sv
package wwdr_pkg;
  typedef enum logic [1:0] {
    WWDR_STOPPED,
    WWDR_RUNNING,
    WWDR_FIRED
  } wwdr_state_t;

  typedef logic [11:0] wwdr_val_t;
endpackage : wwdr_pkg

// ### rtl/wwdr_top.sv
// Operation
// - window register holds 12-bit limit, upper bits zero, reset to 0xfff by standby.
// - window limit is compared with the down-counter as upper bound for refresh.
// - reload while running only safe when counter below limit and above zero, else reset.
// - window read returns low-power domain copy, valid once update flag clears.
// - reload key loads down-counter with programmed reload value.
// - update flag set on write start, cleared when value lands, at most five slow ticks.
`timescale 1ns/1ps
`default_nettype none
`include "wwdr_consts.svh"
module wwdr_top #(
  parameter int LP_TICKS = `WWDR_LP_TICKS
) (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // slow oscillator pin and power state
  input wire logic rc_clk_pin,
  input wire logic standby,
  // watchdog result
  output logic wdg_reset_req,
  output logic wdg_running
);
  wwdr_lp_if lp_bus ();

  wwdr_lp_domain #(
    .TICKS(LP_TICKS)
  ) u_lp (
    .hclk(hclk),
    .hresetn(hresetn),
    .lp(lp_bus.lp)
  );

  // slow clock pin: three stages, a rising edge counts once stages two and three agree
  logic [2:0] rc_sync_reg;
  logic rc_level_reg;
  wire logic rc_tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_sync_reg <= 3'h0;
      rc_level_reg <= 1'b0;
    end else if (ce) begin
      rc_sync_reg <= {rc_sync_reg[1:0], rc_clk_pin};
      if (rc_sync_reg[1] == rc_sync_reg[2]) begin
        rc_level_reg <= rc_sync_reg[2];
      end
    end
  end

  // the accepted level only moves on agreement, so a one-cycle glitch is not a tick
  assign rc_tick = rc_sync_reg[1] & rc_sync_reg[2] & ~rc_level_reg;

  // ahb address phase capture
  wire logic addr_phase;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;

  assign addr_phase = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (ce) begin
      wr_pend_reg <= addr_phase & hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // data phase write decode
  wire logic wr_key;
  wire logic wr_div;
  wire logic wr_reload;
  wire logic wr_window;
  wire logic [15:0] key_code;
  wire logic reload_cmd;
  wire logic start_cmd;

  assign wr_key = wr_pend_reg && (wr_addr_reg == `WWDR_OFS_KEY);
  assign wr_div = wr_pend_reg && (wr_addr_reg == `WWDR_OFS_DIV);
  assign wr_reload = wr_pend_reg && (wr_addr_reg == `WWDR_OFS_RELOAD);
  assign wr_window = wr_pend_reg && (wr_addr_reg == `WWDR_OFS_WINDOW);
  assign key_code = hwdata[`WWDR_KEY_W-1:0];
  assign reload_cmd = wr_key && (key_code == `WWDR_KEY_RELOAD);
  assign start_cmd = wr_key && (key_code == `WWDR_KEY_START);

  // writes cross into the low-power domain copy
  assign lp_bus.ce = ce;
  assign lp_bus.rc_tick = rc_tick;
  assign lp_bus.standby = standby;
  assign lp_bus.wr_req = {wr_window, wr_reload, wr_div};
  assign lp_bus.wr_data = hwdata[`WWDR_VAL_W-1:0];

  // prescaler from the divider field
  wire logic [2:0] div_field;
  wire logic [2:0] div_eff;
  wire logic [7:0] div_last;
  logic [7:0] pre_cnt_reg;
  wire logic cnt_tick;

  assign div_field = lp_bus.div_val[`WWDR_DIV_W-1:0];
  assign div_eff = (div_field > `WWDR_DIV_SAT) ? `WWDR_DIV_SAT : div_field;
  assign div_last = 8'((`WWDR_DIV_BASE << div_eff) - 9'h001);
  assign cnt_tick = rc_tick && (pre_cnt_reg == div_last);

  // down-counter and window compare
  wwdr_pkg::wwdr_state_t state_reg;
  wwdr_pkg::wwdr_state_t state_next;
  wwdr_pkg::wwdr_val_t cnt_reg;
  wwdr_pkg::wwdr_val_t cnt_next;
  wire logic in_window;

  // the limit is an upper bound; equal to it is already too early
  assign in_window = (cnt_reg < lp_bus.window_val) && (cnt_reg != 12'h000);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      wwdr_pkg::WWDR_STOPPED: begin
        if (start_cmd || reload_cmd) begin
          cnt_next = lp_bus.reload_val;
        end
        if (start_cmd) begin
          state_next = wwdr_pkg::WWDR_RUNNING;
        end
      end
      wwdr_pkg::WWDR_RUNNING: begin
        if (reload_cmd) begin
          if (in_window) begin
            cnt_next = lp_bus.reload_val;
          end else begin
            state_next = wwdr_pkg::WWDR_FIRED;
          end
        end else if (cnt_tick) begin
          if (cnt_reg == 12'h000) begin
            state_next = wwdr_pkg::WWDR_FIRED;
          end else begin
            cnt_next = cnt_reg - 12'h001;
          end
        end
      end
      wwdr_pkg::WWDR_FIRED: begin
        // held until the system reset that this request causes
        state_next = wwdr_pkg::WWDR_FIRED;
      end
      default: begin
        state_next = wwdr_pkg::WWDR_FIRED;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= wwdr_pkg::WWDR_STOPPED;
      cnt_reg <= `WWDR_RELOAD_RST;
      pre_cnt_reg <= 8'h00;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (rc_tick) begin
        pre_cnt_reg <= (pre_cnt_reg == div_last) ? 8'h00 : pre_cnt_reg + 8'h01;
      end
    end
  end

  // read data is built in the address phase so it stands in the data phase
  wire logic [2:0] pend_view;
  logic [31:0] rdata_next;

  // a write in its data phase already shows as pending to a read right behind it
  assign pend_view = lp_bus.pend | (lp_bus.wr_req & ~lp_bus.pend);

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (haddr[7:0])
      `WWDR_OFS_DIV: rdata_next[`WWDR_DIV_W-1:0] = div_field;
      `WWDR_OFS_RELOAD: rdata_next[`WWDR_VAL_W-1:0] = lp_bus.reload_val;
      `WWDR_OFS_STATUS: rdata_next[`WWDR_NUM_PEND-1:0] = pend_view;
      `WWDR_OFS_WINDOW: rdata_next[`WWDR_VAL_W-1:0] = lp_bus.window_val;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      wdg_reset_req <= 1'b0;
      wdg_running <= 1'b0;
    end else if (ce) begin
      if (addr_phase && !hwrite) begin
        hrdata <= rdata_next;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wdg_reset_req <= (state_next == wwdr_pkg::WWDR_FIRED);
      wdg_running <= (state_next == wwdr_pkg::WWDR_RUNNING);
    end
  end
endmodule : wwdr_top
`default_nettype wire

// ### verification/test_windowed_watchdog_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_windowed_watchdog_regs;
  logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic rc_clk_pin = 1'b0, standby = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, wdg_reset_req, wdg_running;
  int fails = 0, compares = 0;
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
  always #2.5 hclk = ~hclk;
  // slow tick every 40 cycles keeps a transfer far longer than a bus cycle
  always begin repeat (20) @(posedge hclk); rc_clk_pin <= ~rc_clk_pin; end
  wwdr_top #(.LP_TICKS(2)) u_wwdr_top (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rc_clk_pin(rc_clk_pin), .standby(standby),
    .wdg_reset_req(wdg_reset_req), .wdg_running(wdg_running));
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    `CHK(x, e)
  endtask : chk_rd
  task settle;
    logic [31:0] s;
    int n;
    n = 0;
    do begin bus(1'b0, 8'h0c, 32'h0, s); n++; end while (s !== 32'h0 && n < 100);
    `CHK(s, 32'h0)
  endtask : settle
  task do_reset;
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask : do_reset
  task t_reset_values;
    chk_rd(8'h04, 32'h0);
    chk_rd(8'h08, 32'hfff);
    chk_rd(8'h0c, 32'h0);
    chk_rd(8'h10, 32'hfff);
    chk_rd(8'h00, 32'h0);
    chk_rd(8'h14, 32'h0);
  endtask : t_reset_values
  task t_updates;
    logic [7:0] a;
    logic [31:0] s;
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 8'h04 : (i == 1) ? 8'h08 : 8'h10;
      wr(a, 32'h5a5a5a5d);
      bus(1'b0, 8'h0c, 32'h0, s);
      `CHK(s, 32'h1 << i)
      wr(a, 32'h0); // dropped while pending
      settle;
      chk_rd(a, (i == 0) ? 32'h5 : 32'ha5d);
    end
    wr(8'h04, 32'h0);
    settle;
  endtask : t_updates
  task t_standby;
    @(posedge hclk) standby <= 1'b1;
    repeat (3) @(posedge hclk);
    standby <= 1'b0;
    chk_rd(8'h10, 32'hfff);
    chk_rd(8'h08, 32'hfff);
  endtask : t_standby
  task t_freeze;
    wr(8'h08, 32'h123);
    ce <= 1'b0;
    repeat (200) @(posedge hclk);
    ce <= 1'b1;
    chk_rd(8'h0c, 32'h2);
    settle;
    chk_rd(8'h08, 32'h123);
  endtask : t_freeze
  task cfg;
    wr(8'h08, 32'ha);
    wr(8'h10, 32'h5);
    settle;
    wr(8'h00, 32'hcccc);
  endtask : cfg
  task t_early_reload;
    cfg;
    wr(8'h00, 32'haaaa);
    repeat (2) @(posedge hclk);
    `CHK(wdg_reset_req, 1'b1)
    do_reset;
  endtask : t_early_reload
  task t_in_band;
    cfg;
    repeat (1200) @(posedge hclk);
    `CHK(wdg_running, 1'b1)
    wr(8'h00, 32'haaaa);
    repeat (2) @(posedge hclk);
    `CHK(wdg_reset_req, 1'b0)
    repeat (1500) @(posedge hclk);
    `CHK(wdg_reset_req, 1'b0)
    repeat (600) @(posedge hclk);
    `CHK(wdg_reset_req, 1'b1)
  endtask : t_in_band
  task complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    do_reset;
    t_reset_values;
    t_updates;
    t_standby;
    t_freeze;
    t_early_reload;
    t_in_band;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    $display("unexpected at %0t: timeout", $time);
    fails++;
    complete_run;
  end
endmodule : test_windowed_watchdog_regs
`default_nettype wire

// ### verification/wwdr_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module wwdr_top_properties #(
  parameter int LP_TICKS = 3
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // watchdog
  input wire logic wdg_reset_req,
  input wire logic wdg_running
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic rd_taken;
  assign rd_taken = ce && hsel && htrans[1] && hready && !hwrite;
  sequence rd_at(logic [7:0] a);
    rd_taken && haddr[7:0] == a;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
  a_no_wait: assert property ((ce && hresetn) |=> hreadyout) else $error("wait state");
  a_data_stands: assert property (!rd_taken |=> $stable(hrdata)) else $error("read data moved");
  a_fire_held: assert property (wdg_reset_req |=> wdg_reset_req) else $error("fire dropped");
  a_fire_running: assert property ($rose(wdg_reset_req) |-> $past(wdg_running))
    else $error("fire while stopped");
  a_window_upper: assert property (rd_at(8'h10) |=> hrdata[31:12] == 20'h00000)
    else $error("window upper bits");
  a_reload_upper: assert property (rd_at(8'h08) |=> hrdata[31:12] == 20'h00000)
    else $error("reload upper bits");
  a_status_upper: assert property (rd_at(8'h0c) |=> hrdata[31:3] == 29'h0)
    else $error("status upper bits");
  a_key_zero: assert property (rd_at(8'h00) |=> hrdata == 32'h0) else $error("key read");
endmodule : wwdr_top_properties
bind wwdr_top wwdr_top_properties #(.LP_TICKS(LP_TICKS)) u_wwdr_top_properties (
  .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .wdg_reset_req, .wdg_running);
`default_nettype wire
